// *** isrm_register_map.sv ***
// Sub-address register map behind a two-wire bus target.
// Assumes a status word, buffer and interrupt sources from the core.
//
// Function
// - Registers sit as sub-addresses under one address.
// - Multi-byte values move lowest byte first.
// - Reads of unmapped sub-addresses return 0xFF.
// - Reads past a register's end return 0xFF.
// - Overlong writes update the start register.
// - Full-length writes at a base are accepted.
// - Multi-byte registers other than status accessed from base only.
// - Status low or top byte writable alone.
// - Status middle bytes ignore writes.
// - Status base takes 1-4 bytes, reads whole.
// - Status top byte read gives bits 31:24.
// - Status second-byte read gives bits 23:8.
// - Locality values 0-4, one-hot modifiers.
// - Highest locality wins simultaneous requests.
// - Ownership access register exists per locality.
// - Other registers are single shared copies.
// - Fixed map of offsets and lengths.
// - Measurement end acts only in locality 4.
// - Measurement start acts only in locality 4.
// - Buffer port carries command and response bytes.
// - Locality 4 buffer writes are measurement data.
// - Locality selector holds value, resets to zero.
// - Locality writes ignored during a measurement.
// - NACKed write data is discarded.
// - NACK any request that cannot be served.
`timescale 1ns/1ns
`include "isrm_params.svh"

module isrm_register_map
  import isrm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `ISRM_DEV_ADDR_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic notReady,
  input wire logic [4:0] locRequest,
  output logic [4:0] locGrant,
  output logic [7:0] locModifier,
  input wire logic [31:0] statusIn,
  output isrm_sts_wr_s statusWr,
  input wire logic [31:0] intEvents,
  input wire logic [31:0] intCapIn,
  output logic [31:0] intEnable,
  output isrm_buf_wr_s bufWr,
  output logic bufRdReq,
  input wire logic [7:0] bufRdData,
  output logic measStart,
  output logic measEnd,
  output logic measActive
);

  isrm_evt_s evt;
  logic [7:0] locSel;
  logic [7:0] accessReg [`ISRM_LOC_COUNT];
  logic [31:0] intStatus;
  logic [7:0] startAddr;
  logic [7:0] curAddr;
  logic [7:0] rdAddr;
  logic [7:0] txByte;
  logic firstByte;
  logic readPend;
  logic wrPend;
  logic [2:0] stgCnt;
  logic [7:0] stg [`ISRM_STAGE_DEPTH];
  logic commitNow, wordFull, locWrite;
  logic [2:0] locIdx;

  // ***************************************************************
  // Bus target
  // ***************************************************************
  isrm_bus_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_target (
    .core_clk(core_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .busy(notReady),
    .txData(txByte),
    .evt(evt)
  );

  // ***************************************************************
  // Decode helpers
  // ***************************************************************
  function automatic logic inWord(input logic [7:0] base,
                                  input logic [7:0] a);
    return a[7:2] == base[7:2];
  endfunction : inWord

  function automatic logic [4:0] pickLoc(input logic [4:0] req);
    logic [4:0] g;
    g = 5'h00;
    for (int i = 0; i < `ISRM_LOC_COUNT; i++) begin
      if (req[i]) begin
        g = 5'h01 << i;
      end
    end
    return g;
  endfunction : pickLoc

  // Byte at address a of a read that began at st
  function automatic logic [7:0] readMap(input logic [7:0] st,
                                         input logic [7:0] a);
    logic [7:0] v;
    logic [4:0] sh;
    v = `ISRM_FILL;
    sh = {a[1:0], 3'b000};
    if (st == `ISRM_OFS_LOC && a == `ISRM_OFS_LOC) begin
      v = locSel;
    end else if (st == `ISRM_OFS_ACCESS && a == `ISRM_OFS_ACCESS) begin
      v = accessReg[locIdx];
    end else if (st == `ISRM_OFS_INT_EN && inWord(st, a)) begin
      v = intEnable[sh +: 8];
    end else if (st == `ISRM_OFS_INT_ST && inWord(st, a)) begin
      v = intStatus[sh +: 8];
    end else if (st == `ISRM_OFS_INT_CAP && inWord(st, a)) begin
      v = intCapIn[sh +: 8];
    end else if (inWord(`ISRM_OFS_STS, st) && inWord(`ISRM_OFS_STS, a)) begin
      v = statusIn[sh +: 8];
    end
    return v;
  endfunction : readMap

  assign locIdx = locSel[2:0];
  assign locModifier = `ISRM_MOD_BASE << locIdx;
  assign locGrant = pickLoc(locRequest);

  // ***************************************************************
  // Transfer tracking and address pointer
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      startAddr <= 8'h00;
      curAddr <= 8'h00;
      rdAddr <= 8'h00;
      firstByte <= 1'b0;
      readPend <= 1'b0;
    end else begin
      readPend <= evt.txReq;
      if (evt.addrHit) begin
        // First read byte is requested with the address hit
        firstByte <= ~evt.isRead;
        rdAddr <= startAddr;
        if (evt.isRead && startAddr != `ISRM_OFS_BUF) begin
          curAddr <= startAddr + 8'h01;
        end else begin
          curAddr <= startAddr;
        end
      end else if (evt.rxValid && firstByte) begin
        firstByte <= 1'b0;
        startAddr <= evt.rxData;
        curAddr <= evt.rxData;
      end else if (evt.rxValid || evt.txReq) begin
        if (evt.txReq) begin
          rdAddr <= curAddr;
        end
        if (startAddr != `ISRM_OFS_BUF) begin
          curAddr <= curAddr + 8'h01;
        end
      end
    end
  end

  // ***************************************************************
  // Read data path
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txByte <= `ISRM_FILL;
      bufRdReq <= 1'b0;
    end else begin
      bufRdReq <= evt.txReq && startAddr == `ISRM_OFS_BUF;
      if (readPend) begin
        if (startAddr == `ISRM_OFS_BUF) begin
          txByte <= bufRdData;
        end else begin
          txByte <= readMap(startAddr, rdAddr);
        end
      end
    end
  end

  // ***************************************************************
  // Write staging, committed at stop or repeated start
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPend <= 1'b0;
      stgCnt <= 3'h0;
      for (int i = 0; i < `ISRM_STAGE_DEPTH; i++) begin
        stg[i] <= 8'h00;
      end
    end else if (evt.abort || evt.start || evt.stop) begin
      wrPend <= 1'b0;
      stgCnt <= 3'h0;
    end else if (evt.rxValid && !firstByte &&
                 startAddr != `ISRM_OFS_BUF) begin
      wrPend <= 1'b1;
      if (stgCnt != `ISRM_WORD_LEN) begin
        stg[stgCnt[1:0]] <= evt.rxData;
        stgCnt <= stgCnt + 3'h1;
      end
    end
  end

  assign commitNow = wrPend && (evt.start || evt.stop);
  assign wordFull = stgCnt == `ISRM_WORD_LEN;
  assign locWrite = commitNow && startAddr == `ISRM_OFS_LOC &&
                    !measActive && stg[0] <= `ISRM_LOC_MAX;

  // ***************************************************************
  // Buffer port forwarding
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bufWr <= '0;
    end else begin
      bufWr.valid <= evt.rxValid && !firstByte &&
                     startAddr == `ISRM_OFS_BUF;
      bufWr.data <= evt.rxData;
      bufWr.measData <= locSel == `ISRM_LOC_MAX;
    end
  end

  // ***************************************************************
  // Locality selector and per-locality ownership access
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      locSel <= `ISRM_LOC_RESET;
    end else if (locWrite) begin
      locSel <= stg[0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `ISRM_LOC_COUNT; i++) begin
        accessReg[i] <= 8'h00;
      end
    end else if (commitNow && startAddr == `ISRM_OFS_ACCESS) begin
      accessReg[locIdx] <= stg[0];
    end
  end

  // ***************************************************************
  // Shared interrupt enable and status words
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intEnable <= 32'h0000_0000;
    end else if (commitNow && wordFull &&
                 startAddr == `ISRM_OFS_INT_EN) begin
      intEnable <= {stg[3], stg[2], stg[1], stg[0]} &
                   `ISRM_INT_EN_MASK;
    end
  end

  // Write one clears; a new event in the same cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intStatus <= 32'h0000_0000;
    end else if (commitNow && wordFull &&
                 startAddr == `ISRM_OFS_INT_ST) begin
      intStatus <= (intStatus & ~{stg[3], stg[2], stg[1], stg[0]}) |
                   intEvents;
    end else begin
      intStatus <= intStatus | intEvents;
    end
  end

  // ***************************************************************
  // Status word writes: low and top bytes only
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      statusWr <= '0;
    end else begin
      statusWr.wrLow <= commitNow && startAddr == `ISRM_OFS_STS;
      statusWr.lowByte <= stg[0];
      if (commitNow && startAddr == `ISRM_OFS_STS_TOP) begin
        statusWr.wrHigh <= 1'b1;
        statusWr.highByte <= stg[0];
      end else begin
        statusWr.wrHigh <= commitNow && wordFull &&
                           startAddr == `ISRM_OFS_STS;
        statusWr.highByte <= stg[3];
      end
    end
  end

  // ***************************************************************
  // Measurement strobes, locality 4 only
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      measStart <= 1'b0;
      measEnd <= 1'b0;
      measActive <= 1'b0;
    end else begin
      measStart <= commitNow && startAddr == `ISRM_OFS_MEAS_START &&
                   locSel == `ISRM_LOC_MAX;
      measEnd <= commitNow && startAddr == `ISRM_OFS_MEAS_END &&
                 locSel == `ISRM_LOC_MAX;
      if (measStart) begin
        measActive <= 1'b1;
      end else if (measEnd) begin
        measActive <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence readAt(logic [7:0] s, logic [7:0] a);
    evt.txReq && startAddr == s && curAddr == a;
  endsequence

  sequence commitAt(logic [7:0] s);
    commitNow && startAddr == s;
  endsequence

  chk_loc_hold: assert property (
    !locWrite |=> $stable(locSel))
    else $error("locality selector changed without a write");

  chk_loc_locked: assert property (
    commitAt(`ISRM_OFS_LOC) ##0 measActive |=> $stable(locSel))
    else $error("locality changed during a measurement");

  chk_start_loc4: assert property (
    commitAt(`ISRM_OFS_MEAS_START) |=> measStart == (locSel == 8'h04))
    else $error("measurement start not tied to locality 4");

  chk_end_loc4: assert property (
    commitAt(`ISRM_OFS_MEAS_END) |=> measEnd == (locSel == 8'h04))
    else $error("measurement end not tied to locality 4");

  chk_gap_fill: assert property (
    readAt(8'h01, 8'h01) |-> ##2 txByte == 8'hFF)
    else $error("reserved sub-address did not read 0xFF");

  chk_overrun_fill: assert property (
    readAt(8'h00, 8'h01) |-> ##2 txByte == 8'hFF)
    else $error("read past register end did not read 0xFF");

  chk_sts_top: assert property (
    readAt(8'h1B, 8'h1B) |-> ##2 txByte == $past(statusIn[31:24]))
    else $error("status top byte read wrong");

  chk_sts_mid: assert property (
    readAt(8'h19, 8'h1A) |-> ##2 txByte == $past(statusIn[23:16]))
    else $error("status middle read wrong");

  chk_int_en_lsb: assert property (
    readAt(8'h08, 8'h08) |-> ##2 txByte == $past(intEnable[7:0]))
    else $error("interrupt enable low byte not first");

  chk_mod_onehot: assert property (
    locSel == 8'h04 |-> locModifier == 8'h10)
    else $error("locality modifier not one-hot");

  chk_prio_top: assert property (
    locRequest[4] |-> locGrant == 5'b10000)
    else $error("locality 4 did not win");

  chk_abort_drop: assert property (
    evt.abort |=> !wrPend && stgCnt == 3'h0 && !statusWr.wrLow)
    else $error("aborted write data kept");

  chk_buf_noinc: assert property (
    evt.rxValid && !firstByte && startAddr == 8'h24 |=> $stable(curAddr))
    else $error("buffer port address advanced");

  chk_sts_top_wr: assert property (
    commitAt(`ISRM_OFS_STS) ##0 stgCnt == 3'h2 |=> !statusWr.wrHigh)
    else $error("middle status write reached top byte");

  chk_int_en_len: assert property (
    commitAt(`ISRM_OFS_INT_EN) ##0 stgCnt == 3'h1 |=> $stable(intEnable))
    else $error("short interrupt enable write took effect");

endmodule : isrm_register_map

// *** isrm_params.svh ***
// Constants of the sub-address register map: offsets, masks, counts.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef ISRM_PARAMS_SVH
`define ISRM_PARAMS_SVH

// ***************************************************************
// Bus target
// ***************************************************************
`define ISRM_DEV_ADDR_DEF 7'h2E
`define ISRM_BIT_COUNT 4'h8

// ***************************************************************
// Register offsets
// ***************************************************************
`define ISRM_OFS_LOC 8'h00
`define ISRM_OFS_ACCESS 8'h04
`define ISRM_OFS_INT_EN 8'h08
`define ISRM_OFS_INT_ST 8'h10
`define ISRM_OFS_INT_CAP 8'h14
`define ISRM_OFS_STS 8'h18
`define ISRM_OFS_STS_TOP 8'h1B
`define ISRM_OFS_MEAS_END 8'h20
`define ISRM_OFS_BUF 8'h24
`define ISRM_OFS_MEAS_START 8'h28

// ***************************************************************
// Values and layouts
// ***************************************************************
`define ISRM_FILL 8'hFF
`define ISRM_LOC_RESET 8'h00
`define ISRM_LOC_MAX 8'h04
`define ISRM_LOC_COUNT 5
`define ISRM_MOD_BASE 8'h01
`define ISRM_INT_EN_MASK 32'h8000_0087
`define ISRM_WORD_LEN 3'h4
`define ISRM_STAGE_DEPTH 4

`endif

// *** isrm_pkg.sv ***
// Types shared by the bus target and the register map.
// Assumes the constants header is compiled alongside.
package isrm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } isrm_state_e;

  // Events from the bus target, one-cycle pulses except isRead, which holds its value
  typedef struct packed {
    logic start;
    logic stop;
    logic addrHit;
    logic isRead;
    logic rxValid;
    logic [7:0] rxData;
    logic txReq;
    logic abort;
  } isrm_evt_s;

  typedef struct packed {
    logic wrLow;
    logic wrHigh;
    logic [7:0] lowByte;
    logic [7:0] highByte;
  } isrm_sts_wr_s;

  typedef struct packed {
    logic valid;
    logic measData;
    logic [7:0] data;
  } isrm_buf_wr_s;

endpackage : isrm_pkg

// *** isrm_bus_target.sv ***
// Two-wire bus target: start/stop detection, address match, byte shift.
// Assumes SCL and SDA arrive asynchronously; SDA is open drain.
`timescale 1ns/1ns
`include "isrm_params.svh"

module isrm_bus_target
  import isrm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `ISRM_DEV_ADDR_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic busy,
  input wire logic [7:0] txData,
  output isrm_evt_s evt
);

  logic [2:0] sclS;
  logic [2:0] sdaS;
  isrm_state_e state;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic masterAck;
  logic sclRise, sclFall, startSeen, stopSeen;

  // ***************************************************************
  // Pin synchronisers and edges
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclS <= 3'h7;
      sdaS <= 3'h7;
    end else begin
      sclS <= {sclS[1:0], sclIn};
      sdaS <= {sdaS[1:0], sdaIn};
    end
  end

  assign sclRise = sclS[1] & ~sclS[2];
  assign sclFall = ~sclS[1] & sclS[2];
  assign startSeen = sclS[1] & sclS[2] & sdaS[2] & ~sdaS[1];
  assign stopSeen = sclS[1] & sclS[2] & ~sdaS[2] & sdaS[1];
  assign sdaOut = 1'b0;

  // ***************************************************************
  // Bit-level state machine
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      shiftReg <= 8'h00;
      bitCnt <= 4'h0;
      masterAck <= 1'b0;
      sdaOe <= 1'b0;
      evt <= '0;
    end else begin
      evt <= '0;
      evt.isRead <= evt.isRead;
      if (startSeen) begin
        state <= ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
        evt.start <= 1'b1;
      end else if (stopSeen) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
        evt.stop <= 1'b1;
      end else begin
        unique case (state)
          ST_IDLE: ;
          ST_ADDR, ST_RX: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaS[1]};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == `ISRM_BIT_COUNT) begin
              // Address NACK when unable to serve or not ours
              if (state == ST_ADDR) begin
                if (shiftReg[7:1] == DEV_ADDR && !busy) begin
                  sdaOe <= 1'b1;
                  state <= ST_ADDR_ACK;
                  evt.addrHit <= 1'b1;
                  evt.isRead <= shiftReg[0];
                  evt.txReq <= shiftReg[0];
                end else begin
                  state <= ST_IDLE;
                end
              end else if (busy) begin
                // Data NACK ends the transfer and drops it
                state <= ST_IDLE;
                evt.abort <= 1'b1;
              end else begin
                sdaOe <= 1'b1;
                state <= ST_RX_ACK;
                evt.rxValid <= 1'b1;
                evt.rxData <= shiftReg;
              end
            end
          end
          ST_ADDR_ACK, ST_RX_ACK: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (state == ST_ADDR_ACK && evt.isRead) begin
                state <= ST_TX;
                shiftReg <= txData;
                sdaOe <= ~txData[7];
              end else begin
                state <= ST_RX;
                sdaOe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall) begin
              if (bitCnt == `ISRM_BIT_COUNT) begin
                sdaOe <= 1'b0;
                state <= ST_TX_ACK;
              end else begin
                shiftReg <= {shiftReg[6:0], 1'b1};
                sdaOe <= ~shiftReg[6];
              end
            end
          end
          ST_TX_ACK: begin
            if (sclRise) begin
              masterAck <= ~sdaS[1];
              evt.txReq <= ~sdaS[1];
            end else if (sclFall) begin
              bitCnt <= 4'h0;
              if (masterAck) begin
                state <= ST_TX;
                shiftReg <= txData;
                sdaOe <= ~txData[7];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : isrm_bus_target

// *** isrm_host_model.sv ***
// Host-side two-wire bus controller model with byte-level tasks.
// Assumes the bench resolves SDA from sdaDrv and the device enable.
`timescale 1ns/1ns

module isrm_host_model (
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrv
);
  // ***************
  // Bus conditions
  // ***************
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Start or repeated start
  task automatic start();
    sdaDrv = 1'b1;
    #40 scl = 1'b1;
    #40 sdaDrv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask : start

  task automatic stop();
    sdaDrv = 1'b0;
    #40 scl = 1'b1;
    #40 sdaDrv = 1'b1;
    #80;
  endtask : stop

  // One byte plus acknowledge; last high releases SDA in the ack slot
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaDrv = d[i];
      #40 scl = 1'b1;
      #40 q[i] = sdaLine;
      #40 scl = 1'b0;
      #40;
    end
    sdaDrv = last;
    #40 scl = 1'b1;
    #40 ack = ~sdaLine;
    #40 scl = 1'b0;
    #40;
  endtask : xfer
endmodule : isrm_host_model

// *** test_i2c_subaddress_register_map.sv ***
// Self-checking bench for the sub-address register map.
// Assumes the host model drives the bus; SDA has a pull-up.
`timescale 1ns/1ns

module test_i2c_subaddress_register_map;
  import isrm_pkg::*;
  typedef struct {logic [7:0] sub; int n; logic [31:0] exp;} isrm_row_s;
  localparam logic [6:0] DEV = 7'h2E;
  logic core_clk, rst, notReady, scl, sdaDrv, sdaOe, measStart, measActive;
  logic [4:0] locRequest, locGrant;
  logic [7:0] locModifier, bufRdData, hiByte, loByte;
  logic sdaOut, bufRdReq, measEnd, sawEnd;
  logic [31:0] statusIn, intEvents, intCapIn, intEnable, v;
  isrm_sts_wr_s statusWr;
  isrm_buf_wr_s bufWr;
  logic sawStart, a;
  logic [8:0] bufSeen;
  logic [7:0] q;
  int n_fail, num_checks, nRdReq;
  wire sdaLine = sdaDrv & ~sdaOe;
  isrm_row_s rows [10] = '{
    '{8'h18, 4, 32'hA1B2_C3D4}, '{8'h1B, 1, 32'h0000_00A1},
    '{8'h19, 2, 32'h0000_B2C3}, '{8'h14, 4, 32'h0000_0087},
    '{8'h01, 1, 32'h0000_00FF}, '{8'h09, 1, 32'h0000_00FF},
    '{8'h00, 2, 32'h0000_FF00}, '{8'h2C, 1, 32'h0000_00FF},
    '{8'h24, 2, 32'h0000_5A5A}, '{8'h04, 1, 32'h0000_0022}};

  isrm_register_map #(.DEV_ADDR(DEV)) i_dut (.core_clk(core_clk),
    .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .notReady(notReady), .locRequest(locRequest), .locGrant(locGrant),
    .locModifier(locModifier), .statusIn(statusIn), .statusWr(statusWr),
    .intEvents(intEvents), .intCapIn(intCapIn), .intEnable(intEnable),
    .bufWr(bufWr), .bufRdReq(bufRdReq), .bufRdData(bufRdData),
    .measStart(measStart), .measEnd(measEnd), .measActive(measActive));
  isrm_host_model i_host (.sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

  // ***************
  // Helpers
  // ***************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulses caught for later checks
  always @(posedge core_clk) begin
    if (rst) begin
      sawStart <= 1'b0;
      sawEnd <= 1'b0;
      nRdReq <= 0;
    end else begin
      if (measStart) sawStart <= 1'b1;
      if (measEnd) sawEnd <= 1'b1;
      if (bufRdReq) nRdReq <= nRdReq + 1;
      if (statusWr.wrLow) loByte <= statusWr.lowByte;
      if (statusWr.wrHigh) hiByte <= statusWr.highByte;
      if (bufWr.valid) bufSeen <= {bufWr.measData, bufWr.data};
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic hdr(input logic [7:0] sub);
    i_host.start();
    i_host.xfer({DEV, 1'b0}, 1'b1, q, a);
    i_host.xfer(sub, 1'b1, q, a);
  endtask : hdr

  task automatic wr(input logic [7:0] sub, input int n, input logic [31:0] d);
    hdr(sub);
    for (int i = 0; i < n; i++) i_host.xfer(d[8*i+:8], 1'b1, q, a);
    i_host.stop();
    #100;
  endtask : wr

  task automatic rd(input logic [7:0] sub, input int n);
    v = '0;
    hdr(sub);
    i_host.start();
    i_host.xfer({DEV, 1'b1}, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'hFF, i == n - 1, q, a);
      v[8*i+:8] = q;
    end
    i_host.stop();
    #100;
  endtask : rd

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #400000;
    n_fail++;
    close_out();
  end

  // ***************
  // Tests
  // ***************
  initial begin
    rst = 1'b1;
    notReady = 1'b0;
    locRequest = 5'b0_1011;
    statusIn = 32'hA1B2_C3D4;
    intEvents = '0;
    intCapIn = 32'h0000_0087;
    bufRdData = 8'h5A;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(locModifier, 8'h01);
    check(intEnable, 32'h0);
    check(sdaOut, 1'b0);
    check(locGrant, 5'b0_1000);
    locRequest = 5'b1_0001;
    #10 check(locGrant, 5'b1_0000);
    $display("reset and priority done");
    wr(8'h04, 1, 32'h22);
    foreach (rows[i]) begin
      rd(rows[i].sub, rows[i].n);
      check(v, rows[i].exp);
    end
    check(nRdReq, 2);
    $display("read table done");
    wr(8'h08, 4, 32'h8000_0087);
    check(intEnable, 32'h8000_0087);
    wr(8'h08, 1, 32'h0);
    check(intEnable, 32'h8000_0087);
    hdr(8'h08);
    for (int i = 0; i < 4; i++) i_host.xfer(8'h00, 1'b1, q, a);
    notReady = 1'b1;
    i_host.xfer(8'h00, 1'b1, q, a);
    check(a, 1'b0);
    i_host.stop();
    notReady = 1'b0;
    #100 check(intEnable, 32'h8000_0087);
    wr(8'h1B, 1, 32'h0000_005C);
    check(hiByte, 8'h5C);
    wr(8'h18, 1, 32'h0000_003C);
    check(loByte, 8'h3C);
    wr(8'h18, 2, 32'h0000_1133);
    check({hiByte, loByte}, 16'h5C33);
    wr(8'h28, 1, 32'h1);
    check(sawStart, 1'b0);
    $display("write cases done");
    wr(8'h00, 1, 32'h4);
    check(locModifier, 8'h10);
    rd(8'h04, 1);
    check(v, 32'h0);
    wr(8'h28, 1, 32'h1);
    check({sawStart, measActive}, 2'b11);
    wr(8'h00, 1, 32'h0);
    check(locModifier, 8'h10);
    wr(8'h24, 1, 32'h77);
    check(bufSeen, 9'h177);
    wr(8'h20, 1, 32'h1);
    check({sawEnd, measActive}, 2'b10);
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(locModifier, 8'h01);
    check(intEnable, 32'h0);
    wr(8'h00, 1, 32'h2);
    check(locModifier, 8'h04);
    $display("measurement done");
    close_out();
  end
endmodule : test_i2c_subaddress_register_map
